// ---- core/mdls_core.sv ----
`timescale 1ns/1ps
// phase readout, default phase select and manual latency override
module mdls_core (
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    // register port
    input  wire mdls_pkg::mdls_reg_req_s     reg_req,
    output logic      [mdls_pkg::DATA_W-1:0] reg_rdata,
    // phase comparator and port mode, asynchronous
    input  wire logic [7:0]                  phase_compare_code,
    input  wire logic                        dual_port_mode,
    // samples
    input  wire logic [mdls_pkg::SAMPLE_W-1:0] sample_in,
    output logic      [mdls_pkg::SAMPLE_W-1:0] sample_out,
    // status
    output logic      [1:0]                  active_phase_select
);
    typedef struct packed {
        logic [7:0]                  code_s1;
        logic [7:0]                  code_s2;
        logic                        mode_s1;
        logic                        mode_s2;
        logic [1:0]                  ps_auto;
        mdls_pkg::mdls_ctrl_s        ctrl;
        logic [1:0]                  ps_active;
        logic [2:0]                  tap;
        logic [mdls_pkg::DATA_W-1:0] rdata;
    } mdls_core_s;

    mdls_core_s st;
    mdls_core_s next_st;

    // returns {known, select}; unknown codes leave the select unchanged
    function automatic logic [2:0] dual_default(input logic [7:0] c);
        unique case (c)
            8'h03, 8'h04, 8'h05, 8'h15, 8'h25: dual_default = 3'h6;
            8'h35, 8'h45, 8'h55, 8'h54, 8'h53: dual_default = 3'h4;
            8'h52, 8'h51, 8'h50, 8'h40, 8'h30: dual_default = 3'h5;
            8'h20, 8'h10, 8'h00, 8'h01, 8'h02: dual_default = 3'h7;
            default:                           dual_default = 3'h0;
        endcase
    endfunction

    function automatic logic [2:0] single_default(input logic [7:0] c);
        unique case (c)
            8'h03, 8'h04, 8'h05, 8'h15, 8'h25,
            8'h20, 8'h10, 8'h00, 8'h01, 8'h02: single_default = 3'h4;
            8'h35, 8'h45, 8'h55, 8'h54, 8'h53,
            8'h52, 8'h51, 8'h50, 8'h40, 8'h30: single_default = 3'h6;
            default:                           single_default = 3'h0;
        endcase
    endfunction

    // position in the latency cycle; each step forward is one sample earlier
    function automatic logic [1:0] ps_rank(input logic [1:0] ps, input logic dual);
        if (dual) begin
            unique case (ps)
                2'h2: ps_rank = 2'h0;
                2'h0: ps_rank = 2'h1;
                2'h1: ps_rank = 2'h2;
                2'h3: ps_rank = 2'h3;
            endcase
        end else begin
            ps_rank = {1'b0, ps[1]};
        end
    endfunction

    logic [2:0] lookup;
    logic [1:0] ps_eff;
    logic [1:0] step;

    always_comb begin
        next_st         = st;
        next_st.code_s1 = phase_compare_code;
        next_st.code_s2 = st.code_s1;
        next_st.mode_s1 = dual_port_mode;
        next_st.mode_s2 = st.mode_s1;
        lookup = st.mode_s2 ? dual_default(st.code_s2) : single_default(st.code_s2);
        if (lookup[2]) begin
            next_st.ps_auto = lookup[1:0];
        end
        if (reg_req.wr && reg_req.addr == mdls_pkg::CTRL_ADDR) begin
            next_st.ctrl.manual_sync_enable = reg_req.wdata[mdls_pkg::MANUAL_BIT];
            next_st.ctrl.phase_select       = reg_req.wdata[mdls_pkg::PS_LSB +: 2];
        end
        // the written select only counts while manual mode is set
        ps_eff = st.ctrl.manual_sync_enable ? st.ctrl.phase_select : st.ps_auto;
        next_st.ps_active = ps_eff;
        step = st.mode_s2 ? 2'(ps_rank(ps_eff, 1'b1) - ps_rank(st.ps_auto, 1'b1))
                          : 2'(ps_rank(ps_eff, 1'b0) ^ ps_rank(st.ps_auto, 1'b0));
        next_st.tap = 3'(mdls_pkg::BASE_TAP - {1'b0, step});
        next_st.rdata = '0;
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                mdls_pkg::CTRL_ADDR:  next_st.rdata = {5'h00, st.ctrl};
                mdls_pkg::PHASE_ADDR: next_st.rdata = st.code_s2;
                default:              next_st.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st           <= '0;
            st.ps_auto   <= mdls_pkg::PS_RESET;
            st.ps_active <= mdls_pkg::PS_RESET;
            st.ctrl      <= mdls_pkg::CTRL_RESET[2:0];
            st.tap       <= mdls_pkg::BASE_TAP;
            st.code_s1   <= mdls_pkg::CODE_RESET;
            st.code_s2   <= mdls_pkg::CODE_RESET;
        end else begin
            st <= next_st;
        end
    end

    mdls_delay_line #(
        .WIDTH (mdls_pkg::SAMPLE_W),
        .DEPTH (mdls_pkg::DELAY_DEPTH)
    ) u_delay (
        .clk        (clk),
        .rst_n      (rst_n),
        .sample_in  (sample_in),
        .tap        (st.tap),
        .sample_out (sample_out)
    );

    assign reg_rdata           = st.rdata;
    assign active_phase_select = st.ps_active;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_ctrl_write(logic [7:0] v);
        reg_req.wr && reg_req.addr == mdls_pkg::CTRL_ADDR && reg_req.wdata == v;
    endsequence

    sequence s_manual_applied;
        ##1 st.ctrl.manual_sync_enable && st.ctrl.phase_select == 2'h2 ##1 active_phase_select == 2'h2;
    endsequence

    a_readout_code: assert property (
        reg_req.rd && reg_req.addr == mdls_pkg::PHASE_ADDR |=> reg_rdata == $past(st.code_s2))
        else $error("phase readout does not show the synchronized code");

    a_manual_write: assert property (
        s_ctrl_write(8'h06) |-> s_manual_applied)
        else $error("writing 0x06 did not set manual mode with select 10");

    a_dual_table: assert property (
        st.mode_s2 && st.code_s2 == 8'h25 |=> st.ps_auto == 2'h2)
        else $error("dual-port default select wrong for code 0x25");

    a_dual_late: assert property (
        st.mode_s2 && st.code_s2 == 8'h40 |=> st.ps_auto == 2'h1)
        else $error("dual-port default select wrong for code 0x40");

    a_single_table: assert property (
        !st.mode_s2 && st.code_s2 == 8'h35 |=> st.ps_auto == 2'h2)
        else $error("single-port default select wrong for code 0x35");

    a_override_use: assert property (
        st.ctrl.manual_sync_enable && $stable(st.ctrl) [*2] |-> active_phase_select == st.ctrl.phase_select)
        else $error("manual select not in use");

    a_auto_use: assert property (
        !st.ctrl.manual_sync_enable && $stable(st.ps_auto) [*2] |-> active_phase_select == st.ps_auto)
        else $error("automatic select not in use");

    // judged on the stored select against the automatic one, not on a change of the active select
    a_latency_step: assert property (
        st.mode_s2 && st.ctrl.manual_sync_enable
        && ((st.ps_auto == 2'h2 && st.ctrl.phase_select == 2'h0)
        || (st.ps_auto == 2'h0 && st.ctrl.phase_select == 2'h1)
        || (st.ps_auto == 2'h1 && st.ctrl.phase_select == 2'h3)
        || (st.ps_auto == 2'h3 && st.ctrl.phase_select == 2'h2))
        |=> st.tap == 3'(mdls_pkg::BASE_TAP - 3'h1))
        else $error("one-step select change did not cut exactly one sample");

    a_tap_bound: assert property (
        st.tap <= mdls_pkg::BASE_TAP && st.tap + 3'h3 >= mdls_pkg::BASE_TAP)
        else $error("delay tap outside its range");
endmodule

// ---- core/mdls_delay_line.sv ----
`timescale 1ns/1ps
// sample delay line with a selectable output tap
module mdls_delay_line #(
    parameter int WIDTH = mdls_pkg::SAMPLE_W,
    parameter int DEPTH = mdls_pkg::DELAY_DEPTH
) (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    // samples
    input  wire logic [WIDTH-1:0]         sample_in,
    input  wire logic [$clog2(DEPTH)-1:0] tap,
    output logic      [WIDTH-1:0]         sample_out
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] pipe;
        logic [WIDTH-1:0]            out;
    } mdls_dl_s;

    mdls_dl_s st;
    mdls_dl_s next_st;

    // a tap step of one moves the output by exactly one sample, order kept
    always_comb begin
        next_st      = st;
        next_st.pipe = {st.pipe[DEPTH-2:0], sample_in};
        next_st.out  = st.pipe[tap];
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sample_out = st.out;
endmodule

// ---- inc/mdls_pkg.sv ----
// shared constants and carriers for the multi-DAC latency synchronizer
package mdls_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 8;
    localparam logic [7:0]  CTRL_ADDR       = 8'h05;
    localparam logic [7:0]  PHASE_ADDR      = 8'h06;
    localparam int          MANUAL_BIT      = 2;
    localparam int          PS_LSB          = 0;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;
    localparam logic [7:0]  CODE_RESET      = 8'h00;
    localparam logic [1:0]  PS_RESET        = 2'h2;
    localparam int          SAMPLE_W        = 16;
    localparam int          DELAY_DEPTH     = 8;
    localparam logic [2:0]  BASE_TAP        = 3'h3;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } mdls_reg_req_s;

    typedef struct packed {
        logic       manual_sync_enable;
        logic [1:0] phase_select;
    } mdls_ctrl_s;
endpackage

// ---- sim/mdls_host_model.sv ----
// host side model: register strobes and latency adjustment decisions
`timescale 1ns/1ps
module mdls_host_model (
    // clock
    input  wire logic               clk,
    // register port
    output mdls_pkg::mdls_reg_req_s req
);
    initial req = '0;

    // one strobe cycle, request launched and released on falling edges
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge clk);
        req <= '0;
    endtask

    // {valid, select} that removes one cycle; codes that should not occur keep the default
    function automatic logic [2:0] cut(input logic [7:0] c, input logic dual);
        if (dual) begin
            case (c)
                8'h15, 8'h25: return 3'h4;
                8'h54, 8'h53: return 3'h5;
                8'h40, 8'h30: return 3'h7;
                8'h01, 8'h02: return 3'h6;
                default:      return 3'h0;
            endcase
        end
        // single-port codes count delay to the falling edge
        case (c)
            8'h04, 8'h05, 8'h15, 8'h25: return 3'h6;
            8'h51, 8'h50, 8'h40, 8'h30: return 3'h4;
            default:                    return 3'h0;
        endcase
    endfunction

    // smallest of three decoded delays, in tenths of a sample cycle
    function automatic int min3(input int a, input int b, input int c);
        int m;
        m = (a < b) ? a : b;
        return (m < c) ? m : c;
    endfunction

    // a dac is late when its delay is 0.4 cycles or more above the smallest
    function automatic logic late(input int tenths, input int min_tenths);
        return (tenths - min_tenths) >= 4;
    endfunction
endmodule

// ---- sim/multi_dac_latency_sync_test.sv ----
// self-checking bench for the latency synchronizer core
`timescale 1ns/1ps
module multi_dac_latency_sync_test;
    logic                    clk    = 1'b0;
    logic                    rst_n  = 1'b0;
    mdls_pkg::mdls_reg_req_s req;
    logic [7:0]              rdata;
    logic [7:0]              code   = 8'h03;
    logic                    dual   = 1'b1;
    logic [15:0]             s_in   = 16'h0000;
    logic [15:0]             s_out;
    logic [1:0]              aps;
    int                      fails  = 0;
    int                      checked = 0;
    logic [7:0] codes [20] = '{8'h03, 8'h04, 8'h05, 8'h15, 8'h25, 8'h35, 8'h45, 8'h55, 8'h54, 8'h53,
                               8'h52, 8'h51, 8'h50, 8'h40, 8'h30, 8'h20, 8'h10, 8'h00, 8'h01, 8'h02};
    logic [1:0] ps_dual [4] = '{2'h2, 2'h0, 2'h1, 2'h3};

    initial forever #2 clk = ~clk;
    // ramp stream makes latency readable as a plain difference
    always @(negedge clk) s_in <= s_in + 16'h0001;

    mdls_host_model mdls_host_model_inst (.clk(clk), .req(req));
    mdls_core mdls_core_inst (.clk(clk), .rst_n(rst_n), .reg_req(req), .reg_rdata(rdata),
        .phase_compare_code(code), .dual_port_mode(dual), .sample_in(s_in), .sample_out(s_out),
        .active_phase_select(aps));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d failures %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic test_tables();
        for (int m = 0; m < 2; m++) begin
            dual = m[0];
            for (int i = 0; i < 20; i++) begin
                code = codes[i];
                repeat (6) @(negedge clk);
                mdls_host_model_inst.access(1'b0, mdls_pkg::PHASE_ADDR, 8'h00);
                check(rdata, codes[i]);
                check(aps, m ? ps_dual[i/5] : ((i > 4 && i < 15) ? 2'h2 : 2'h0));
            end
        end
        $display("test tables done");
    endtask

    task automatic test_manual();
        dual = 1'b0;
        code = 8'h15;
        repeat (6) @(negedge clk);
        mdls_host_model_inst.access(1'b1, mdls_pkg::CTRL_ADDR, 8'h02);
        repeat (4) @(negedge clk);
        check(aps, 2'h0);
        mdls_host_model_inst.access(1'b1, mdls_pkg::CTRL_ADDR, 8'h06);
        repeat (4) @(negedge clk);
        check(aps, 2'h2);
        mdls_host_model_inst.access(1'b0, mdls_pkg::CTRL_ADDR, 8'h00);
        check(rdata, 8'h06);
        mdls_host_model_inst.access(1'b1, mdls_pkg::PHASE_ADDR, 8'h00);
        mdls_host_model_inst.access(1'b0, mdls_pkg::PHASE_ADDR, 8'h00);
        check(rdata, 8'h15);
        mdls_host_model_inst.access(1'b0, 8'h07, 8'h00);
        check(rdata, 8'h00);
        mdls_host_model_inst.access(1'b1, mdls_pkg::CTRL_ADDR, 8'h00);
        $display("test manual done");
    endtask

    task automatic test_latency(input logic m, input logic [7:0] c, input int t);
        logic [15:0] d0;
        logic [2:0]  adj;
        int          mn;
        // the other two dacs sit at 0.2 and 0.1 cycles
        mn = mdls_host_model_inst.min3(t, 2, 1);
        check(16'(mn), 16'h0001);
        check(mdls_host_model_inst.late(t, mn), 1'b1);
        check(mdls_host_model_inst.late(mn + 3, mn), 1'b0);
        dual = m;
        code = c;
        repeat (8) @(negedge clk);
        d0 = s_in - s_out;
        adj = mdls_host_model_inst.cut(c, m);
        mdls_host_model_inst.access(1'b1, mdls_pkg::CTRL_ADDR, {6'h01, adj[1:0]});
        repeat (8) @(negedge clk);
        check(aps, adj[1:0]);
        check(s_in - s_out, d0 - 16'h0001);
        code = (c == 8'h54) ? 8'h53 : 8'h05;
        repeat (8) @(negedge clk);
        check(aps, adj[1:0]);
        mdls_host_model_inst.access(1'b1, mdls_pkg::CTRL_ADDR, 8'h00);
        $display("test latency done");
    endtask

    // generous bound: the whole sequence needs well under a thousand cycles
    initial begin
        #80000;
        fails++;
        report_and_stop();
    end

    initial begin
        repeat (16) @(negedge clk);
        check(aps, 2'h2);
        check(s_out, 16'h0000);
        rst_n = 1'b1;
        mdls_host_model_inst.access(1'b0, mdls_pkg::CTRL_ADDR, 8'h00);
        check(rdata, 8'h00);
        $display("test reset done");
        test_tables();
        test_manual();
        test_latency(1'b1, 8'h54, 6);
        test_latency(1'b0, 8'h04, 6);
        report_and_stop();
    end
endmodule
